// ===== hdl/flash_link_device.sv
// Flash device end: frame capture on the link clock, acceptance and latch on clk
// Function
// (R1) All bytes travel most significant bit first
// (R2) First bit on first rising edge
// (R3) Frame opens with one opcode byte
// (R4) Host raises select after last bit
// (R5) Read commands followed by data-out phase
// (R6) Write commands need whole bytes at end
// (R7) Partial program byte keeps latch set
// (R8) Short program or wake commands ignored
// (R9) Program needs address plus one data byte
// (R10) Erase needs exactly a 24-bit address
// (R11) Array access ignored while cycle busy
// (R12) Complement, lower blocks protected by level
// (R13) Complement, upper blocks protected by level
// (R14) Complement granule, top sliver left open
// (R15) Complement granule, bottom sliver left open
// (R16) Modifying commands need the latch set
// (R17) Latch cleared by reset and completions
// (R18) Protected target changes nothing, latch kept
`default_nettype none
module flash_link_device #(
	parameter int CNT_W = 12,
	// Arbitrary identifier value
	parameter logic [7:0] DEVICE_ID = 8'h5a
) (
	// User clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Link
	flash_link_if.device link,
	// Array state and protection setting
	input wire logic array_busy,
	input wire logic protect_complement,
	input wire logic small_granule_protect,
	input wire logic protect_top_bottom,
	input wire logic protect_level_bit2,
	input wire logic protect_level_bit1,
	input wire logic protect_level_bit0,
	// Accepted commands, rejects and latch state
	output logic exec_valid,
	output logic [7:0] exec_op,
	output logic [23:0] exec_addr,
	output logic [CNT_W-4:0] exec_bytes,
	output logic frame_reject,
	output logic write_enable_latch
);
	localparam int NB_W = CNT_W - 3;
	localparam logic [CNT_W-1:0] OP_END = CNT_W'(flpkg::BYTE_BITS);
	localparam logic [CNT_W-1:0] ADDR_END =
		CNT_W'(flpkg::BYTE_BITS * (1 + flpkg::ADDR_BYTES));
	localparam logic [CNT_W-1:0] WAKE_END =
		CNT_W'(flpkg::BYTE_BITS * flpkg::WAKE_MIN_BYTES);

	////////////////////////////////////////////////////////////////////////
	// Link clock, rising edge: shift in
	logic fresh_q;
	logic tog_q;
	logic tog_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] base;
	logic [7:0] op_q;
	logic [7:0] op_d;
	logic [23:0] addr_q;
	logic [23:0] addr_d;
	logic wel1_q;
	logic wel2_q;
	logic busy1_q;
	logic busy2_q;

	// Select high arms a fresh frame; no link edge is needed to end one
	always_ff @(posedge link.sclk or posedge link.cs_b or negedge rst_b) begin
		if (!rst_b) begin
			fresh_q <= 1'b1;
		end else if (link.cs_b) begin
			fresh_q <= 1'b1;
		end else begin
			fresh_q <= 1'b0;
		end
	end

	always_comb begin
		// (R2) Restart count on first edge
		base = fresh_q ? '0 : cnt_q;
		cnt_d = (&base) ? base : base + 1'b1;
		tog_d = fresh_q ? ~tog_q : tog_q;
		// (R1) (R3) Opcode then address MSB-first
		op_d = (base < OP_END) ? {op_q[6:0], link.serial_data_in} : op_q;
		addr_d = (base >= OP_END && base < ADDR_END) ?
			{addr_q[22:0], link.serial_data_in} : addr_q;
	end

	always_ff @(posedge link.sclk or negedge rst_b) begin
		if (!rst_b) begin
			tog_q <= 1'b0;
			cnt_q <= '0;
			op_q <= 8'h00;
			addr_q <= 24'h000000;
			wel1_q <= 1'b0;
			wel2_q <= 1'b0;
			busy1_q <= 1'b0;
			busy2_q <= 1'b0;
		end else begin
			tog_q <= tog_d;
			cnt_q <= cnt_d;
			op_q <= op_d;
			addr_q <= addr_d;
			wel1_q <= write_enable_latch;
			wel2_q <= wel1_q;
			busy1_q <= array_busy;
			busy2_q <= busy1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link clock, falling edge: shift out
	logic out_q;
	logic out_d;
	logic oe_b_q;
	logic oe_b_d;
	logic talk;
	logic [7:0] tx_byte;

	always_comb begin
		tx_byte = 8'h00;
		if (op_q == flpkg::OP_STATUS_READ) begin
			tx_byte[flpkg::STATUS_BUSY_BIT] = busy2_q;
			tx_byte[flpkg::STATUS_WEL_BIT] = wel2_q;
		end else begin
			tx_byte = DEVICE_ID;
		end
		// (R5) Data-out after status read or wake
		talk = (cnt_q >= OP_END && op_q == flpkg::OP_STATUS_READ) ||
			(cnt_q >= WAKE_END && op_q == flpkg::OP_WAKE_READ_ID);
		oe_b_d = ~talk;
		// (R1) Output byte MSB-first, repeating
		out_d = talk & tx_byte[3'h7 - cnt_q[2:0]];
	end

	always_ff @(negedge link.sclk or posedge link.cs_b or negedge rst_b) begin
		if (!rst_b) begin
			out_q <= 1'b0;
			oe_b_q <= 1'b1;
		end else if (link.cs_b) begin
			out_q <= 1'b0;
			oe_b_q <= 1'b1;
		end else begin
			out_q <= out_d;
			oe_b_q <= oe_b_d;
		end
	end

	assign link.serial_data_out = out_q;
	assign link.data_out_oe_b = oe_b_q;

	////////////////////////////////////////////////////////////////////////
	// User clock: frame end takeover and acceptance
	logic cs1_q;
	logic cs2_q;
	logic cs3_q;
	logic tg1_q;
	logic tg2_q;
	logic seen_q;
	logic seen_d;
	logic wel_q;
	logic wel_d;
	logic ev_q;
	logic ev_d;
	logic rej_q;
	logic rej_d;
	logic [7:0] eop_q;
	logic [23:0] eaddr_q;
	logic [NB_W-1:0] ebytes_q;
	logic frame_end;
	logic aligned;
	logic [NB_W-1:0] nbytes;
	logic kind_write;
	logic guarded;
	logic prot_chk;
	logic len_ok;
	logic prot;
	logic go;

	always_comb begin
		// Frame registers are still once select is high
		frame_end = cs2_q & ~cs3_q & (tg2_q != seen_q);
		seen_d = (cs2_q & ~cs3_q) ? tg2_q : seen_q;
		aligned = (cnt_q[2:0] == 3'h0);
		nbytes = cnt_q[CNT_W-1:3];
		kind_write = 1'b1;
		guarded = 1'b1;
		prot_chk = 1'b0;
		len_ok = 1'b0;
		case (op_q)
			flpkg::OP_WRITE_ENABLE, flpkg::OP_WRITE_DISABLE: begin
				guarded = 1'b0;
				len_ok = (nbytes != '0);
			end
			flpkg::OP_STATUS_WRITE: begin
				len_ok = (nbytes >= NB_W'(flpkg::STATUS_WRITE_MIN)) &&
					(nbytes <= NB_W'(flpkg::STATUS_WRITE_MAX));
			end
			// (R8) (R9) Program minimum length
			flpkg::OP_PAGE_PROGRAM, flpkg::OP_QUAD_PAGE_PROGRAM: begin
				prot_chk = 1'b1;
				// Count includes the opcode, so the minimum must be exceeded
				len_ok = (nbytes > NB_W'(flpkg::PROGRAM_MIN_BYTES));
			end
			// (R10) Erase exact address length
			flpkg::OP_FOUR_K_CLEAR, flpkg::OP_HALF_BLOCK_WIPE, flpkg::OP_BLOCK_WIPE: begin
				prot_chk = 1'b1;
				len_ok = (nbytes == NB_W'(flpkg::ERASE_BYTES));
			end
			// (R8) Wake needs dummy bytes
			flpkg::OP_WAKE_READ_ID: begin
				kind_write = 1'b0;
				guarded = 1'b0;
				len_ok = (nbytes >= NB_W'(flpkg::WAKE_MIN_BYTES));
			end
			default: begin
				kind_write = 1'b0;
				guarded = 1'b0;
			end
		endcase
		// (R12) (R13) (R14) (R15) Range decode
		prot = flpkg::addr_protected(addr_q, protect_complement, small_granule_protect,
			protect_top_bottom, {protect_level_bit2, protect_level_bit1, protect_level_bit0});
		// (R6) (R7) Whole bytes only
		go = frame_end && len_ok && (!kind_write || aligned) &&
			// (R16) (R11) Latch and idle array
			(!guarded || (wel_q && !array_busy)) &&
			// (R18) Protected target refused
			!(prot_chk && prot);
		ev_d = go && (guarded || op_q == flpkg::OP_WAKE_READ_ID);
		rej_d = frame_end && kind_write && !go;
		// (R17) Latch set and cleared
		wel_d = wel_q;
		if (go && op_q == flpkg::OP_WRITE_ENABLE) begin
			wel_d = 1'b1;
		end else if (go && (guarded || op_q == flpkg::OP_WRITE_DISABLE)) begin
			wel_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cs1_q <= 1'b1;
			cs2_q <= 1'b1;
			cs3_q <= 1'b1;
			tg1_q <= 1'b0;
			tg2_q <= 1'b0;
			seen_q <= 1'b0;
			wel_q <= 1'b0;
			ev_q <= 1'b0;
			rej_q <= 1'b0;
			eop_q <= 8'h00;
			eaddr_q <= 24'h000000;
			ebytes_q <= '0;
		end else begin
			cs1_q <= link.cs_b;
			cs2_q <= cs1_q;
			cs3_q <= cs2_q;
			tg1_q <= tog_q;
			tg2_q <= tg1_q;
			seen_q <= seen_d;
			wel_q <= wel_d;
			ev_q <= ev_d;
			rej_q <= rej_d;
			if (ev_d) begin
				eop_q <= op_q;
				eaddr_q <= addr_q;
				ebytes_q <= nbytes - 1'b1;
			end
		end
	end

	assign exec_valid = ev_q;
	assign exec_op = eop_q;
	assign exec_addr = eaddr_q;
	assign exec_bytes = ebytes_q;
	assign frame_reject = rej_q;
	assign write_enable_latch = wel_q;
endmodule : flash_link_device
`default_nettype wire

// ===== hdl/flpkg.sv
// Shared opcodes, frame sizes and protection decode for the flash link
`default_nettype none
package flpkg;
	localparam int BYTE_BITS = 8;
	localparam int ADDR_BYTES = 3;
	localparam int PROGRAM_MIN_BYTES = 4;
	localparam int ERASE_BYTES = 4;
	localparam int STATUS_WRITE_MIN = 2;
	localparam int STATUS_WRITE_MAX = 4;
	localparam int WAKE_MIN_BYTES = 4;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_WEL_BIT = 1;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_WAKE_READ_ID = 8'hab;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
	localparam logic [7:0] OP_FOUR_K_CLEAR = 8'h20;
	localparam logic [7:0] OP_HALF_BLOCK_WIPE = 8'h52;
	localparam logic [7:0] OP_BLOCK_WIPE = 8'hd8;
	localparam logic [2:0] LEVEL_ALL = 3'h0;
	localparam logic [2:0] LEVEL_NONE = 3'h7;
	localparam logic [2:0] GRANULE_CAP = 3'h4;
	localparam logic [7:0] BLOCK_COUNT = 8'h80;
	localparam logic [11:0] GRANULE_COUNT = 12'h800;

	// Only the complement-set half of the map; complement clear reports nothing protected
	function automatic logic addr_protected(input logic [23:0] addr, input logic comp,
		input logic granule, input logic top_bottom, input logic [2:0] level);
		logic [7:0] blk;
		logic [7:0] span;
		logic [11:0] unit;
		logic [11:0] size;
		logic [2:0] lvl;
		blk = {1'b0, addr[22:16]};
		unit = {1'b0, addr[22:12]};
		span = 8'h01 << level;
		lvl = (level > GRANULE_CAP) ? GRANULE_CAP : level;
		size = 12'h001 << (lvl - 3'h1);
		if (!comp || level == LEVEL_NONE) begin
			addr_protected = 1'b0;
		end else if (level == LEVEL_ALL) begin
			addr_protected = 1'b1;
		end else if (!granule) begin
			addr_protected = top_bottom ? (blk >= span) : (blk < BLOCK_COUNT - span);
		end else begin
			addr_protected = top_bottom ? (unit >= size) : (unit < GRANULE_COUNT - size);
		end
	endfunction : addr_protected
endpackage : flpkg
`default_nettype wire

// ===== hdl/flash_link_if.sv
// Serial flash link between the controller and the memory device
`default_nettype none
interface flash_link_if;
	logic cs_b;
	logic sclk;
	logic serial_data_in;
	logic serial_data_out;
	logic data_out_oe_b;
	modport device(input cs_b, input sclk, input serial_data_in,
		output serial_data_out, output data_out_oe_b);
	modport host(output cs_b, output sclk, output serial_data_in,
		input serial_data_out, input data_out_oe_b);
endinterface : flash_link_if
`default_nettype wire

// ===== hdl/flash_link_host.sv
// Flash controller end: builds frames and makes the link clock by division
`default_nettype none
module flash_link_host #(
	parameter int HALF_CYCLES = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Link
	flash_link_if.host link,
	// Request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [7:0] req_opcode,
	input wire logic [23:0] req_addr,
	input wire logic [7:0] req_data,
	input wire logic [3:0] req_tx_bytes,
	input wire logic [3:0] req_rx_bytes,
	input wire logic [2:0] req_extra_bits,
	input wire logic req_write_enable_cmd_first,
	// Answer
	output logic done,
	output logic [7:0] rx_data
);
	localparam logic [7:0] DIV_LOAD = 8'(HALF_CYCLES - 1);

	typedef enum {IDLE, START, SHIFT, TRAIL, GAP} host_state_t;

	function automatic logic frame_bit(input logic [7:0] idx, input logic [7:0] op,
		input logic [23:0] addr, input logic [7:0] data);
		logic [7:0] b;
		case (idx[7:3])
			5'h00: b = op;
			5'h01: b = addr[23:16];
			5'h02: b = addr[15:8];
			5'h03: b = addr[7:0];
			default: b = data;
		endcase
		frame_bit = b[3'h7 - idx[2:0]];
	endfunction : frame_bit

	host_state_t st_q, st_d;
	logic [7:0] div_q, div_d, bit_q, bit_d, rxs_q, rxs_d, rxd_q, rxd_d;
	logic sclk_q, sclk_d, cs_b_q, cs_b_d, mosi_q, mosi_d, pre_q, pre_d;
	logic done_q, done_d, miso1_q, miso2_q;
	logic [7:0] op_q, op_d, data_q, data_d, cur_op, cur_total, cur_tx, rel;
	logic [23:0] addr_q, addr_d;
	logic [3:0] tx_q, tx_d, rx_q, rx_d;
	logic [2:0] ext_q, ext_d;

	always_comb begin
		// (R16) Optional enable frame ahead of the command
		cur_op = pre_q ? flpkg::OP_WRITE_ENABLE : op_q;
		cur_tx = pre_q ? 8'(flpkg::BYTE_BITS) : {5'(tx_q) + 5'h01, 3'h0};
		cur_total = pre_q ? cur_tx : {5'(tx_q) + 5'(rx_q) + 5'h01, 3'h0} + {5'h00, ext_q};
		rel = bit_q - cur_tx;
		st_d = st_q;
		div_d = div_q;
		bit_d = bit_q;
		sclk_d = sclk_q;
		cs_b_d = cs_b_q;
		mosi_d = mosi_q;
		pre_d = pre_q;
		rxs_d = rxs_q;
		rxd_d = rxd_q;
		done_d = 1'b0;
		op_d = op_q;
		addr_d = addr_q;
		data_d = data_q;
		tx_d = tx_q;
		rx_d = rx_q;
		ext_d = ext_q;
		case (st_q)
			IDLE: begin
				if (req_valid) begin
					op_d = req_opcode;
					addr_d = req_addr;
					data_d = req_data;
					tx_d = req_tx_bytes;
					rx_d = req_rx_bytes;
					ext_d = req_extra_bits;
					pre_d = req_write_enable_cmd_first;
					st_d = START;
				end
			end
			START: begin
				// (R3) (R1) Opcode bit 7 leads
				cs_b_d = 1'b0;
				mosi_d = frame_bit(8'h00, cur_op, addr_q, data_q);
				bit_d = 8'h00;
				div_d = DIV_LOAD;
				st_d = SHIFT;
			end
			SHIFT: begin
				if (div_q != 8'h00) begin
					div_d = div_q - 8'h01;
				end else begin
					div_d = DIV_LOAD;
					sclk_d = ~sclk_q;
					if (!sclk_q) begin
						bit_d = bit_q + 8'h01;
						// (R5) Collect device data-out
						if (bit_q >= cur_tx) begin
							rxs_d = {rxs_q[6:0], miso2_q};
							if (rel[2:0] == 3'h7) begin
								rxd_d = {rxs_q[6:0], miso2_q};
							end
						end
					end else if (bit_q == cur_total) begin
						st_d = TRAIL;
					end else begin
						mosi_d = (bit_q < cur_tx) & frame_bit(bit_q, cur_op, addr_q, data_q);
					end
				end
			end
			TRAIL: begin
				if (div_q != 8'h00) begin
					div_d = div_q - 8'h01;
				end else begin
					// (R4) Select rises after final bit
					div_d = DIV_LOAD;
					cs_b_d = 1'b1;
					st_d = GAP;
				end
			end
			GAP: begin
				if (div_q != 8'h00) begin
					div_d = div_q - 8'h01;
				end else if (pre_q) begin
					pre_d = 1'b0;
					st_d = START;
				end else begin
					done_d = 1'b1;
					st_d = IDLE;
				end
			end
			default: st_d = IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= IDLE;
			div_q <= 8'h00;
			bit_q <= 8'h00;
			sclk_q <= 1'b0;
			cs_b_q <= 1'b1;
			mosi_q <= 1'b0;
			pre_q <= 1'b0;
			rxs_q <= 8'h00;
			rxd_q <= 8'h00;
			done_q <= 1'b0;
			miso1_q <= 1'b0;
			miso2_q <= 1'b0;
			op_q <= 8'h00;
			addr_q <= 24'h000000;
			data_q <= 8'h00;
			tx_q <= 4'h0;
			rx_q <= 4'h0;
			ext_q <= 3'h0;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			bit_q <= bit_d;
			sclk_q <= sclk_d;
			cs_b_q <= cs_b_d;
			mosi_q <= mosi_d;
			pre_q <= pre_d;
			rxs_q <= rxs_d;
			rxd_q <= rxd_d;
			done_q <= done_d;
			miso1_q <= link.serial_data_out;
			miso2_q <= miso1_q;
			op_q <= op_d;
			addr_q <= addr_d;
			data_q <= data_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			ext_q <= ext_d;
		end
	end

	assign req_ready = (st_q == IDLE);
	assign link.cs_b = cs_b_q;
	assign link.sclk = sclk_q;
	assign link.serial_data_in = mosi_q;
	assign done = done_q;
	assign rx_data = rxd_q;
endmodule : flash_link_host
`default_nettype wire

// ===== tb/flash_link_sva.sv
// Link checker for the flash controller and device ends
`default_nettype none
module flash_link_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Link
	input wire logic cs_b,
	input wire logic sclk,
	input wire logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic data_out_oe_b
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////////////////////
	sequence s_low4;
		!sclk [*4];
	endsequence
	sequence s_high4;
		sclk [*4];
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	property p_idle_clock;
		cs_b |-> !sclk;
	endproperty
	a_idle_clock: assert property (p_idle_clock)
		else $error("link clock high while deselected");
	property p_drive_off;
		cs_b |-> data_out_oe_b;
	endproperty
	a_drive_off: assert property (p_drive_off)
		else $error("data out driven while deselected");
	property p_first_rise;
		$fell(cs_b) |-> s_low4 ##1 sclk;
	endproperty
	a_first_rise: assert property (p_first_rise)
		else $error("first clock rise misplaced after select");
	property p_high_phase;
		$rose(sclk) |-> s_high4 ##1 !sclk;
	endproperty
	a_high_phase: assert property (p_high_phase)
		else $error("link clock high phase wrong");
	property p_low_phase;
		$fell(sclk) |-> s_low4;
	endproperty
	a_low_phase: assert property (p_low_phase)
		else $error("link clock low phase too short");
	property p_data_hold;
		sclk |-> $stable(serial_data_in);
	endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("input data moved while clock high");
	property p_cs_gap;
		$rose(cs_b) |-> cs_b [*4];
	endproperty
	a_cs_gap: assert property (p_cs_gap)
		else $error("deselect gap too short");
	property p_end_after_bit;
		$rose(cs_b) |-> !sclk && !$past(sclk, 4);
	endproperty
	a_end_after_bit: assert property (p_end_after_bit)
		else $error("select raised inside a bit");
	// Guard on previous enable: turn-on of the drive may move the data too
	property p_dout_on_fall;
		$changed(serial_data_out) && !data_out_oe_b && !$past(data_out_oe_b) |-> $fell(sclk);
	endproperty
	a_dout_on_fall: assert property (p_dout_on_fall)
		else $error("data out changed off a clock fall");
endmodule : flash_link_chk
`default_nettype wire

// ===== tb/test_serial_flash_cmd_framing_protect.sv
// Bench joining controller and device ends over the flash link
`default_nettype none
module test_serial_flash_cmd_framing_protect;
	timeunit 1ns;
	timeprecision 1ps;
	// Arbitrary identifier value
	localparam logic [7:0] ID = 8'h5a;
	localparam int LIMIT = 80000;
	localparam logic [23:0] A = 24'h3c5a96;
	logic clk, rst_b, busy, comp, gran, tb, req_valid, req_wf, ex, rj;
	logic req_ready, done, exec_valid, frame_reject, latch;
	logic [2:0] lvl, req_xb;
	logic [7:0] req_op, eop, rx_data, exec_op;
	logic [23:0] req_a, ead, exec_addr;
	logic [3:0] req_tx, req_rx;
	logic [8:0] eby, exec_bytes;
	int num_errors = 0;
	int compares = 0;
	int cyc = 0;

	flash_link_if link_if ();
	flash_link_host #(.HALF_CYCLES(4)) flash_link_host_inst (.clk(clk), .rst_b(rst_b),
		.link(link_if.host), .req_valid(req_valid), .req_ready(req_ready),
		.req_opcode(req_op), .req_addr(req_a), .req_data(8'hc3), .req_tx_bytes(req_tx),
		.req_rx_bytes(req_rx), .req_extra_bits(req_xb), .req_write_enable_cmd_first(req_wf),
		.done(done), .rx_data(rx_data));
	flash_link_device #(.CNT_W(12), .DEVICE_ID(ID)) flash_link_device_inst (.clk(clk),
		.rst_b(rst_b), .link(link_if.device), .array_busy(busy), .protect_complement(comp),
		.small_granule_protect(gran), .protect_top_bottom(tb), .protect_level_bit2(lvl[2]),
		.protect_level_bit1(lvl[1]), .protect_level_bit0(lvl[0]), .exec_valid(exec_valid),
		.exec_op(exec_op), .exec_addr(exec_addr), .exec_bytes(exec_bytes),
		.frame_reject(frame_reject), .write_enable_latch(latch));
	flash_link_chk flash_link_chk_inst (.clk(clk), .rst_b(rst_b), .cs_b(link_if.cs_b),
		.sclk(link_if.sclk), .serial_data_in(link_if.serial_data_in),
		.serial_data_out(link_if.serial_data_out), .data_out_oe_b(link_if.data_out_oe_b));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Pulses last one cycle, so keep them until the frame is judged
	always @(posedge clk) begin
		cyc <= cyc + 1;
		// A new request clears what the last frame left
		if (req_valid === 1'b1) begin
			ex <= 1'b0;
			rj <= 1'b0;
		end
		if (exec_valid === 1'b1) begin
			ex <= 1'b1;
			eop <= exec_op;
			ead <= exec_addr;
			eby <= exec_bytes;
		end
		if (frame_reject === 1'b1) begin
			rj <= 1'b1;
		end
		if (cyc == LIMIT) begin
			num_errors++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic res(input logic e, input logic r, input logic w);
		chk("exec", {23'h0, e}, {23'h0, ex});
		chk("reject", {23'h0, r}, {23'h0, rj});
		chk("latch", {23'h0, w}, {23'h0, latch});
	endtask : res

	task automatic setp(input logic b, input logic c, input logic g, input logic t,
		input logic [2:0] l);
		@(posedge clk);
		busy <= b;
		comp <= c;
		gran <= g;
		tb <= t;
		lvl <= l;
	endtask : setp

	// Decision lands three cycles after select rises, one cycle before done
	task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [3:0] tx,
		input logic [3:0] rx, input logic [2:0] xb, input logic wf);
		int n;
		n = 0;
		@(posedge clk);
		req_op <= op;
		req_a <= a;
		req_tx <= tx;
		req_rx <= rx;
		req_xb <= xb;
		req_wf <= wf;
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		while (done !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 3000) begin
			num_errors++;
		end
		repeat (6) @(negedge clk);
		chk("ready", 24'h1, {23'h0, req_ready});
	endtask : run

	function automatic logic prot_exp(input logic [23:0] a, input logic g, input logic t,
		input logic [2:0] l);
		int k;
		if (l == 3'h7) return 1'b0;
		if (l == 3'h0) return 1'b1;
		k = g ? ((l > 3'h3) ? 8 : 1 << (l - 3'h1)) : 1 << l;
		if (g) return t ? (int'(a[22:12]) >= k) : (int'(a[22:12]) < 2048 - k);
		return t ? (int'(a[22:16]) >= k) : (int'(a[22:16]) < 128 - k);
	endfunction : prot_exp

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_latch();
		run(flpkg::OP_WRITE_ENABLE, A, 4'h0, 4'h0, 3'h0, 1'b0);
		res(1'b0, 1'b0, 1'b1);
		run(flpkg::OP_WRITE_DISABLE, A, 4'h0, 4'h0, 3'h0, 1'b0);
		res(1'b0, 1'b0, 1'b0);
	endtask : t_latch

	task automatic t_erase();
		logic [7:0] ops [3];
		ops = '{flpkg::OP_FOUR_K_CLEAR, flpkg::OP_HALF_BLOCK_WIPE, flpkg::OP_BLOCK_WIPE};
		foreach (ops[i]) begin
			run(ops[i], A, 4'h3, 4'h0, 3'h0, 1'b1);
			res(1'b1, 1'b0, 1'b0);
			chk("op", {16'h0, ops[i]}, {16'h0, eop});
			chk("addr", A, ead);
			chk("bytes", 24'h3, {15'h0, eby});
			run(ops[i], A, 4'h4, 4'h0, 3'h0, 1'b1);
			res(1'b0, 1'b1, 1'b1);
			run(ops[i], A, 4'h2, 4'h0, 3'h0, 1'b1);
			res(1'b0, 1'b1, 1'b1);
		end
	endtask : t_erase

	task automatic t_program();
		logic [7:0] ops [2];
		ops = '{flpkg::OP_PAGE_PROGRAM, flpkg::OP_QUAD_PAGE_PROGRAM};
		foreach (ops[i]) begin
			run(ops[i], A, 4'h3, 4'h0, 3'h0, 1'b1);
			res(1'b0, 1'b1, 1'b1);
			run(ops[i], A, 4'h4, 4'h0, 3'h3, 1'b0);
			res(1'b0, 1'b1, 1'b1);
			run(ops[i], A, 4'h4, 4'h0, 3'h0, 1'b0);
			res(1'b1, 1'b0, 1'b0);
			chk("bytes", 24'h4, {15'h0, eby});
			run(ops[i], A, 4'h4, 4'h0, 3'h0, 1'b0);
			res(1'b0, 1'b1, 1'b0);
		end
	endtask : t_program

	task automatic t_busy();
		setp(1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
		run(flpkg::OP_PAGE_PROGRAM, A, 4'h4, 4'h0, 3'h0, 1'b1);
		res(1'b0, 1'b1, 1'b1);
		run(flpkg::OP_STATUS_READ, A, 4'h0, 4'h1, 3'h0, 1'b0);
		chk("status", 24'h3, {16'h0, rx_data});
		setp(1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
		run(flpkg::OP_STATUS_READ, A, 4'h0, 4'h1, 3'h0, 1'b0);
		chk("status", 24'h2, {16'h0, rx_data});
		run(flpkg::OP_STATUS_WRITE, A, 4'h1, 4'h0, 3'h0, 1'b0);
		res(1'b1, 1'b0, 1'b0);
		chk("payload", 24'h3c, ead);
	endtask : t_busy

	task automatic t_wake();
		run(flpkg::OP_WAKE_READ_ID, A, 4'h3, 4'h1, 3'h0, 1'b0);
		res(1'b1, 1'b0, 1'b0);
		chk("id", {16'h0, ID}, {16'h0, rx_data});
		run(flpkg::OP_WAKE_READ_ID, A, 4'h2, 4'h0, 3'h0, 1'b0);
		res(1'b0, 1'b0, 1'b0);
	endtask : t_wake

	// Each level probed on both sides of its edge
	task automatic t_protect();
		logic [23:0] e;
		logic [23:0] a;
		logic p;
		int k;
		for (int c = 0; c < 4; c++) begin
			for (int l = 0; l < 8; l++) begin
				k = c[1] ? ((l > 3) ? 8 : (l == 0) ? 1 : 1 << (l - 1)) : 1 << l;
				e = c[1] ? 24'((c[0] ? k : 2048 - k) << 12) : 24'((c[0] ? k : 128 - k) << 16);
				for (int j = 0; j < 2; j++) begin
					a = e - 24'(j);
					p = prot_exp(a, c[1], c[0], 3'(l));
					setp(1'b0, 1'b1, c[1], c[0], 3'(l));
					run(flpkg::OP_FOUR_K_CLEAR, a, 4'h3, 4'h0, 3'h0, 1'b1);
					res(!p, p, p);
				end
			end
		end
	endtask : t_protect

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_b = 1'b0;
		{busy, comp, gran, tb, req_valid, req_wf} = 6'h0;
		{lvl, req_xb, req_tx, req_rx} = 14'h0;
		req_op = 8'h0;
		req_a = 24'h0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		t_latch();
		t_erase();
		t_program();
		t_busy();
		t_wake();
		t_protect();
		end_of_test();
	end
endmodule : test_serial_flash_cmd_framing_protect
`default_nettype wire
